//--- rtl/cci_comparator_ctrl.sv
// comparator control block: register file, routing, change detection and interrupt gating
//
// Summary of operation
// RQ1 - bit 7 shows second comparator result
// RQ2 - bit 6 shows first comparator result
// RQ3 - mode 001: switch picks pin3 or pin0
// RQ4 - mode 010: switch picks pin3/pin2, else pin0
// RQ5 - any output change sets the flag
// RQ6 - flag cleared by zero, set by one
// RQ7 - interrupt needs all three enables set; irq also rises on any unmasked sticky event without them
// RQ8 - flag sets even when enables clear
// RQ9 - control access ends the mismatch
// RQ10 - persisting mismatch keeps setting the flag
// RQ11 - change during read may be missed
// RQ12 - access latches outputs; mismatch is difference
// RQ13 - bits 5:4 read zero; results read-only
// RQ14 - reset forces mode 000, comparators off
// RQ15 - mode 111 turns both comparators off
// RQ16 - comparators run in sleep, change wakes
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
module cci_comparator_ctrl
    import cci_pkg::*;
#(
    parameter int ADR_W = 10
)
(
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             first_cmp_in,
    input  wire logic             second_cmp_in,
    input  wire logic             sleep_active,
    output logic      [1:0]       first_neg_sel,
    output logic      [1:0]       second_neg_sel,
    output logic                  first_cmp_on,
    output logic                  second_cmp_on,
    output logic                  pins_analog,
    output logic                  wake_req,
    output logic                  irq
);

    // byte addresses derived from the register indices
    localparam logic [ADR_W-1:0] CTRL_ADR  = ADR_W'({CCI_CTRL_IDX, 2'b00});
    localparam logic [ADR_W-1:0] FLAGS_ADR = ADR_W'({CCI_FLAGS_IDX, 2'b00});
    localparam logic [ADR_W-1:0] ENA_ADR   = ADR_W'({CCI_ENABLES_IDX, 2'b00});
    localparam logic [ADR_W-1:0] CORE_ADR  = ADR_W'({CCI_CORE_IDX, 2'b00});
    localparam logic [ADR_W-1:0] STAT_ADR  = ADR_W'({CCI_EVT_STAT_IDX, 2'b00});
    localparam logic [ADR_W-1:0] MASK_ADR  = ADR_W'({CCI_EVT_MASK_IDX, 2'b00});

    // bus handshake state
    logic                 ack_q;
    logic [31:0]          rdata_q;
    logic                 req;
    logic                 acc;
    logic                 wr_low;
    logic                 hit_ctrl;
    logic                 hit_flags;
    logic                 hit_ena;
    logic                 hit_core;
    logic                 hit_stat;
    logic                 hit_mask;

    // software visible state
    logic [2:0]           mode_q;
    logic                 switch_q;
    logic                 cmp_irq_flag_q;
    logic                 cmp_irq_enable_q;
    logic                 peripheral_irq_enable_q;
    logic                 global_irq_enable_q;
    logic [CCI_EVT_W-1:0] evt_stat_q;
    logic [CCI_EVT_W-1:0] evt_mask_q;
    logic [CCI_EVT_W-1:0] evt_rd_snap_q;

    // comparator result tracking
    logic [1:0]           res_q;
    logic [1:0]           res_prev_q;
    logic [1:0]           seen_q;
    logic                 mismatch;
    logic [1:0]           res_now;
    logic [CCI_EVT_W-1:0] evt_new;

    // routing decode outputs before registering
    logic [1:0]           first_sel_c;
    logic [1:0]           second_sel_c;
    logic                 first_on_c;
    logic                 second_on_c;
    logic                 analog_c;

    // interrupt outputs
    logic                 irq_q;
    logic                 wake_q;
    logic                 cmp_irq_req;

    // request decode; an access completes at the edge where ack is high
    assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
    assign acc    = wb_cyc_i & wb_stb_i & ack_q;
    assign wr_low = acc & wb_we_i & wb_sel_i[0];

    assign hit_ctrl  = (wb_adr_i == CTRL_ADR);
    assign hit_flags = (wb_adr_i == FLAGS_ADR);
    assign hit_ena   = (wb_adr_i == ENA_ADR);
    assign hit_core  = (wb_adr_i == CORE_ADR);
    assign hit_stat  = (wb_adr_i == STAT_ADR);
    assign hit_mask  = (wb_adr_i == MASK_ADR);

    // mode decoder kept apart so the routing table is easy to extend
    cci_route u_route (
        .cmp_mode_field   (mode_q),
        .input_switch_sel (switch_q),
        .first_neg_sel    (first_sel_c),
        .second_neg_sel   (second_sel_c),
        .first_on         (first_on_c),
        .second_on        (second_on_c),
        .pins_analog      (analog_c)
    );

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // read data captured with the request so it is stable while ack is high
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdata_q <= 32'h0000_0000; // unmapped reads return zero
            if (hit_ctrl) begin
                rdata_q[CCI_SECOND_RES_BIT] <= res_q[1]; // RQ1
                rdata_q[CCI_FIRST_RES_BIT]  <= res_q[0]; // RQ2
                rdata_q[CCI_SWITCH_BIT]     <= switch_q; // RQ13
                rdata_q[CCI_MODE_LSB +: CCI_MODE_W] <= mode_q;
            end else if (hit_flags) begin
                rdata_q[CCI_FLAG_BIT] <= cmp_irq_flag_q;
            end else if (hit_ena) begin
                rdata_q[CCI_ENABLE_BIT] <= cmp_irq_enable_q;
            end else if (hit_core) begin
                rdata_q[CCI_PERIPHERAL_IRQ_ENABLE_BIT] <= peripheral_irq_enable_q;
                rdata_q[CCI_GIE_BIT]  <= global_irq_enable_q;
            end else if (hit_stat) begin
                rdata_q[CCI_EVT_W-1:0] <= evt_stat_q;
            end else if (hit_mask) begin
                rdata_q[CCI_EVT_W-1:0] <= evt_mask_q;
            end
        end
    end

    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;

    // control register: only switch and mode are writable, results are read-only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_q   <= CCI_CTRL_RST[CCI_MODE_LSB +: CCI_MODE_W]; // RQ14
            switch_q <= CCI_CTRL_RST[CCI_SWITCH_BIT];
        end else if (wr_low && hit_ctrl) begin
            mode_q   <= wb_dat_i[CCI_MODE_LSB +: CCI_MODE_W]; // RQ13
            switch_q <= wb_dat_i[CCI_SWITCH_BIT]; // RQ13
        end
    end

    // enable bits for the three-level gating
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmp_irq_enable_q        <= CCI_BYTE_RST[CCI_ENABLE_BIT];
            peripheral_irq_enable_q <= CCI_BYTE_RST[CCI_PERIPHERAL_IRQ_ENABLE_BIT];
            global_irq_enable_q     <= CCI_BYTE_RST[CCI_GIE_BIT];
        end else if (wr_low) begin
            if (hit_ena) begin
                cmp_irq_enable_q <= wb_dat_i[CCI_ENABLE_BIT];
            end
            if (hit_core) begin
                peripheral_irq_enable_q <= wb_dat_i[CCI_PERIPHERAL_IRQ_ENABLE_BIT];
                global_irq_enable_q     <= wb_dat_i[CCI_GIE_BIT];
            end
        end
    end

    // routing outputs registered so the analog switches see clean levels
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            first_neg_sel  <= CCI_PIN0;
            second_neg_sel <= CCI_PIN0;
            first_cmp_on   <= 1'b0; // RQ14
            second_cmp_on  <= 1'b0; // RQ14
            pins_analog    <= 1'b1;
        end else begin
            first_neg_sel  <= first_sel_c; // RQ3
            second_neg_sel <= second_sel_c; // RQ4
            first_cmp_on   <= first_on_c; // RQ15
            second_cmp_on  <= second_on_c; // RQ15
            pins_analog    <= analog_c;
        end
    end

    // a powered-down comparator reads zero; sleep does not stop sampling
    assign res_now = {second_cmp_in & second_cmp_on, first_cmp_in & first_cmp_on}; // RQ16

    // result sampling plus one-cycle history, two flops per comparator
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            res_q      <= CCI_RES_RST;
            res_prev_q <= CCI_RES_RST;
        end else begin
            res_q      <= res_now; // RQ1 RQ2
            res_prev_q <= res_q;
        end
    end

    // any control access captures the outputs and so ends the mismatch
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            seen_q <= CCI_RES_RST;
        end else if (acc && hit_ctrl) begin
            seen_q <= res_q; // RQ9 RQ12
        end
    end

    // mismatch against the last captured value, evaluated every cycle
    assign mismatch = (res_q != seen_q); // RQ12

    // flag: a standing mismatch sets it each cycle and beats a software clear;
    // the change is compared against the pre-access capture, so nothing is missed
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cmp_irq_flag_q <= CCI_BYTE_RST[CCI_FLAG_BIT];
        end else if (mismatch) begin
            cmp_irq_flag_q <= 1'b1; // RQ5 RQ8 RQ10 RQ11
        end else if (wr_low && hit_flags) begin
            cmp_irq_flag_q <= wb_dat_i[CCI_FLAG_BIT]; // RQ6
        end
    end

    // gated delivery needs all three enables
    assign cmp_irq_req = cmp_irq_flag_q & cmp_irq_enable_q
                       & peripheral_irq_enable_q & global_irq_enable_q; // RQ7

    // per-comparator change events plus wake events
    always_comb begin
        evt_new                     = '0;
        evt_new[CCI_EVT_FIRST_BIT]  = res_q[0] ^ res_prev_q[0];
        evt_new[CCI_EVT_SECOND_BIT] = res_q[1] ^ res_prev_q[1];
        evt_new[CCI_EVT_WAKE_BIT]   = wake_q;
    end

    // snapshot of status bits handed out by a read; only those are cleared
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            evt_rd_snap_q <= CCI_EVT_RST;
        end else if (req && !wb_we_i && hit_stat) begin
            evt_rd_snap_q <= evt_stat_q;
        end
    end

    // sticky status: clear on read, a new event in the same cycle survives
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            evt_stat_q <= CCI_EVT_RST;
        end else if (acc && !wb_we_i && hit_stat) begin
            evt_stat_q <= (evt_stat_q & ~evt_rd_snap_q) | evt_new;
        end else begin
            evt_stat_q <= evt_stat_q | evt_new;
        end
    end

    // event mask, same layout as status
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            evt_mask_q <= CCI_EVT_RST;
        end else if (wr_low && hit_mask) begin
            evt_mask_q <= wb_dat_i[CCI_EVT_W-1:0];
        end
    end

    // wake needs only the local enable, since the core is stopped in sleep
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= sleep_active & cmp_irq_flag_q & cmp_irq_enable_q & ~wake_q; // RQ16
        end
    end

    assign wake_req = wake_q;

    // one level line: gated flag or any unmasked sticky event
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= cmp_irq_req | (|(evt_stat_q & evt_mask_q)); // RQ7
        end
    end

    assign irq = irq_q;

endmodule

//--- rtl/cci_pkg.sv
// package with register map, field layout, reset values and mode codes of the comparator control block
package cci_pkg;

    // register indices; the bus byte address is four times the index
    localparam logic [7:0] CCI_CTRL_IDX     = 8'h1f;
    localparam logic [7:0] CCI_FLAGS_IDX    = 8'h0c;
    localparam logic [7:0] CCI_ENABLES_IDX  = 8'h20;
    localparam logic [7:0] CCI_CORE_IDX     = 8'h0b;
    localparam logic [7:0] CCI_EVT_STAT_IDX = 8'h21;
    localparam logic [7:0] CCI_EVT_MASK_IDX = 8'h22;

    // comparator_control field positions
    localparam int CCI_SECOND_RES_BIT = 7;
    localparam int CCI_FIRST_RES_BIT  = 6;
    localparam int CCI_SWITCH_BIT     = 3;
    localparam int CCI_MODE_LSB       = 0;
    localparam int CCI_MODE_W         = 3;

    // interrupt related bit positions
    localparam int CCI_FLAG_BIT   = 6;
    localparam int CCI_ENABLE_BIT = 6;
    localparam int CCI_PERIPHERAL_IRQ_ENABLE_BIT   = 6;
    localparam int CCI_GIE_BIT    = 7;

    // event status / mask layout
    localparam int CCI_EVT_FIRST_BIT  = 0;
    localparam int CCI_EVT_SECOND_BIT = 1;
    localparam int CCI_EVT_WAKE_BIT   = 2;
    localparam int CCI_EVT_W          = 3;

    // values after reset
    localparam logic [7:0] CCI_CTRL_RST    = 8'h00;
    localparam logic [7:0] CCI_BYTE_RST    = 8'h00;
    localparam logic [1:0] CCI_RES_RST     = 2'h0;
    localparam logic [2:0] CCI_EVT_RST     = 3'h0;

    // pin selection codes for an inverting input
    localparam logic [1:0] CCI_PIN0 = 2'h0;
    localparam logic [1:0] CCI_PIN1 = 2'h1;
    localparam logic [1:0] CCI_PIN2 = 2'h2;
    localparam logic [1:0] CCI_PIN3 = 2'h3;

    // comparator mode field encodings
    typedef enum logic [2:0] {
        CCI_MODE_RESET  = 3'b000,
        CCI_MODE_SWITCH = 3'b001,
        CCI_MODE_PAIR   = 3'b010,
        CCI_MODE_M3     = 3'b011,
        CCI_MODE_M4     = 3'b100,
        CCI_MODE_M5     = 3'b101,
        CCI_MODE_M6     = 3'b110,
        CCI_MODE_OFF    = 3'b111
    } cci_mode_type;

endpackage

//--- rtl/cci_route.sv
// input routing decoder: mode field and switch bit to inverting-input selections
`timescale 1ns/10ps
module cci_route
    import cci_pkg::*;
(
    input  wire logic [2:0] cmp_mode_field,
    input  wire logic       input_switch_sel,
    output logic [1:0]      first_neg_sel,
    output logic [1:0]      second_neg_sel,
    output logic            first_on,
    output logic            second_on,
    output logic            pins_analog
);

    cci_mode_type mode;

    assign mode = cci_mode_type'(cmp_mode_field);

    // decode per mode; unlisted modes use a plain two-comparator layout
    always_comb begin
        first_neg_sel  = CCI_PIN0;
        second_neg_sel = CCI_PIN1;
        first_on       = 1'b1;
        second_on      = 1'b1;
        pins_analog    = 1'b1;
        case (mode)
            CCI_MODE_RESET: begin
                first_on  = 1'b0; // RQ14
                second_on = 1'b0; // RQ14
            end
            CCI_MODE_SWITCH: begin
                first_neg_sel = input_switch_sel ? CCI_PIN3 : CCI_PIN0; // RQ3
                second_on     = 1'b0;
            end
            CCI_MODE_PAIR: begin
                first_neg_sel  = input_switch_sel ? CCI_PIN3 : CCI_PIN0; // RQ4
                second_neg_sel = input_switch_sel ? CCI_PIN2 : CCI_PIN0; // RQ4
            end
            CCI_MODE_OFF: begin
                first_on    = 1'b0; // RQ15
                second_on   = 1'b0; // RQ15
                pins_analog = 1'b0; // pins free for digital use
            end
            default: begin
                first_neg_sel  = CCI_PIN0;
                second_neg_sel = CCI_PIN1;
            end
        endcase
    end

endmodule

//--- verif/cci_comparator_ctrl_sva.sv
// port-level assertion checker for the comparator control block
`timescale 1ns/10ps
module cci_comparator_ctrl_sva
    import cci_pkg::*;
#(
    parameter int ADR_W = 10
)
(
    input wire logic             clock,
    input wire logic             rstn,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic             first_cmp_in,
    input wire logic             second_cmp_in,
    input wire logic             sleep_active,
    input wire logic [1:0]       first_neg_sel,
    input wire logic [1:0]       second_neg_sel,
    input wire logic             first_cmp_on,
    input wire logic             second_cmp_on,
    input wire logic             pins_analog,
    input wire logic             wake_req,
    input wire logic             irq
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // answered read of the control register
    sequence s_ctrl_rd;
        wb_ack_o && !wb_we_i && wb_adr_i == ADR_W'({CCI_CTRL_IDX, 2'b00});
    endsequence
    // a result bit needs a steady input and a powered comparator for a few cycles
    sequence s_steady(on, inp);
        ($stable(inp) && on)[*4];
    endsequence
    property p_result(on, inp, res);
        s_steady(on, inp) ##0 s_ctrl_rd |-> res == inp;
    endproperty

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
    a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_reserved_zero: assert property (s_ctrl_rd |-> wb_dat_o[5:4] == 2'b00)
        else $error("reserved control bits set");
    a_second_result: assert property (p_result(second_cmp_on, second_cmp_in, wb_dat_o[7]))
        else $error("second result bit wrong");
    a_first_result: assert property (p_result(first_cmp_on, first_cmp_in, wb_dat_o[6]))
        else $error("first result bit wrong");
    a_off_mode: assert property (!pins_analog |-> !first_cmp_on && !second_cmp_on)
        else $error("comparator powered while off");
    a_pair_route: assert property (second_neg_sel == CCI_PIN2 |-> first_neg_sel == CCI_PIN3 && second_cmp_on)
        else $error("pair routing wrong");
    a_wake_pulse: assert property (wake_req |-> $past(sleep_active) ##1 !wake_req)
        else $error("wake pulse wrong");
    a_reset_state: assert property ($rose(rstn) |-> pins_analog && !irq && !first_cmp_on && !second_cmp_on)
        else $error("reset state wrong");
endmodule

bind cci_comparator_ctrl cci_comparator_ctrl_sva #(.ADR_W(ADR_W)) u_sva (
    .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .first_cmp_in(first_cmp_in),
    .second_cmp_in(second_cmp_in), .sleep_active(sleep_active), .first_neg_sel(first_neg_sel),
    .second_neg_sel(second_neg_sel), .first_cmp_on(first_cmp_on), .second_cmp_on(second_cmp_on),
    .pins_analog(pins_analog), .wake_req(wake_req), .irq(irq)
);

//--- verif/cci_comparator_ctrl_test.sv
// self-checking bench for the comparator control block
`timescale 1ns/10ps
module cci_comparator_ctrl_test
    import cci_pkg::*;
;
    localparam logic [9:0] A_CTL  = {CCI_CTRL_IDX, 2'b00};
    localparam logic [9:0] A_FLG  = {CCI_FLAGS_IDX, 2'b00};
    localparam logic [9:0] A_ENA  = {CCI_ENABLES_IDX, 2'b00};
    localparam logic [9:0] A_CORE = {CCI_CORE_IDX, 2'b00};
    localparam logic [9:0] A_STAT = {CCI_EVT_STAT_IDX, 2'b00};
    localparam logic [9:0] A_MASK = {CCI_EVT_MASK_IDX, 2'b00};
    logic        clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, first_cmp_in, second_cmp_in;
    logic        sleep_active, first_cmp_on, second_cmp_on, pins_analog, wake_req, irq;
    logic [3:0]  wb_sel_i;
    logic [9:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd_v;
    logic [1:0]  first_neg_sel, second_neg_sel;
    int          miscompares, compares, wakes, wake_base;

    cci_comparator_ctrl #(.ADR_W(10)) DUT (
        .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .first_cmp_in(first_cmp_in), .second_cmp_in(second_cmp_in),
        .sleep_active(sleep_active), .first_neg_sel(first_neg_sel), .second_neg_sel(second_neg_sel),
        .first_cmp_on(first_cmp_on), .second_cmp_on(second_cmp_on), .pins_analog(pins_analog),
        .wake_req(wake_req), .irq(irq)
    );

    // clock and wake pulse counter
    always #12.5 clock = ~clock;
    // counted mid-cycle so the count never races a check made at the rising edge
    always @(negedge clock) if (wake_req === 1'b1) wakes++;

    task automatic end_of_test();
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle; held until ack is sampled, only the watchdog ends a missing ack
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, 24'h00_0000, d, s};
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rd_v = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask
    task automatic rc(input logic [9:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00, 4'h1);
        chk(nm, rd_v, {24'h00_0000, e});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // watchdog; the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_of_test();
    end

    initial begin
        logic [1:0] fs, ss;
        logic       on1, on2;
        {clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
        {first_cmp_in, second_cmp_in, sleep_active, miscompares, compares} = '0;
        tick(5);
        rstn <= 1'b1;
        tick(1);
        chk("reset outputs", 32'({first_cmp_on, second_cmp_on, pins_analog, irq}), 32'h2);
        rc(A_CTL, 8'h00, "ctrl reset");
        wr(A_CTL, 8'hff);
        rc(A_CTL, 8'h0f, "ctrl read-only bits");
        bus(1'b1, A_CTL, 8'h02, 4'h0);
        rc(A_CTL, 8'h0f, "lane off write");
        rc(10'h3fc, 8'h00, "unmapped");
        // power for every mode and switch setting, routing of each powered comparator
        for (int m = 0; m < 8; m++) begin
            for (int s = 0; s < 2; s++) begin
                wr(A_CTL, {4'h0, s[0], m[2:0]});
                tick(3);
                on1 = m != 0 && m != 7;
                on2 = on1 && m != 1;
                fs = (m == 1 || m == 2) && s == 1 ? CCI_PIN3 : CCI_PIN0;
                ss = m == 2 ? (s == 1 ? CCI_PIN2 : CCI_PIN0) : CCI_PIN1;
                chk("power", 32'({first_cmp_on, second_cmp_on, pins_analog}), 32'({on1, on2, m != 7}));
                if (on1) chk("first route", 32'(first_neg_sel), 32'(fs));
                if (on2) chk("second route", 32'(second_neg_sel), 32'(ss));
                rc(A_CTL, {4'h0, s[0], m[2:0]}, "ctrl readback");
            end
        end
        // flag from a change with all enables clear, and the mismatch that keeps it set
        wr(A_CTL, 8'h02);
        wr(A_FLG, 8'h00);
        first_cmp_in <= 1'b1;
        tick(4);
        chk("irq gated", 32'(irq), 32'h0);
        rc(A_FLG, 8'h40, "flag set");
        wr(A_FLG, 8'h00);
        rc(A_FLG, 8'h40, "flag persists");
        rc(A_CTL, 8'h42, "first result");
        wr(A_FLG, 8'h00);
        rc(A_FLG, 8'h00, "flag cleared");
        {first_cmp_in, second_cmp_in} <= 2'b01;
        tick(4);
        rc(A_CTL, 8'h82, "second result");
        wr(A_FLG, 8'h00);
        rc(A_FLG, 8'h00, "flag after access");
        // software set flag through the three enables
        wr(A_ENA, 8'h40);
        wr(A_CORE, 8'h40);
        wr(A_FLG, 8'h40);
        rc(A_FLG, 8'h40, "flag written");
        chk("irq no global", 32'(irq), 32'h0);
        wr(A_CORE, 8'hc0);
        tick(2);
        chk("irq enabled", 32'(irq), 32'h1);
        wr(A_FLG, 8'h00);
        tick(2);
        chk("irq cleared", 32'(irq), 32'h0);
        // sticky event status, cleared by read, masked per bit
        wr(A_CORE, 8'h00);
        bus(1'b0, A_STAT, 8'h00, 4'h1);
        wr(A_MASK, 8'h03);
        second_cmp_in <= 1'b0;
        tick(4);
        chk("irq event", 32'(irq), 32'h1);
        rc(A_CTL, 8'h02, "ctrl event");
        rc(A_STAT, 8'h02, "event second");
        rc(A_STAT, 8'h00, "event read clear");
        tick(2);
        chk("irq event clear", 32'(irq), 32'h0);
        wr(A_MASK, 8'h00);
        first_cmp_in <= 1'b1;
        tick(4);
        chk("irq masked", 32'(irq), 32'h0);
        rc(A_CTL, 8'h42, "ctrl masked");
        rc(A_STAT, 8'h01, "event first");
        // wake from sleep on a change, contents kept
        wr(A_FLG, 8'h00);
        sleep_active <= 1'b1;
        wake_base = wakes;
        first_cmp_in <= 1'b0;
        // flag two edges after the change, wake one edge later; a standing flag pulses again later
        tick(4);
        chk("wake count", 32'(wakes - wake_base), 32'h1);
        rc(A_CTL, 8'h02, "ctrl kept");
        sleep_active <= 1'b0;
        tick(2);
        end_of_test();
    end
endmodule
